// File: logic/dsw_pkg.sv
`default_nettype none
package dsw_pkg;
    localparam int WORD_BITS = 16;
    localparam int CODE_BITS = 12;
    localparam int MODE_HI_POS = 13;
    localparam int MODE_LO_POS = 12;
    localparam int CNT_BITS = 5;
    localparam logic [4:0] LAST_EDGE = 5'h10;
    localparam logic [11:0] CODE_RESET = 12'h000;
    localparam logic [11:0] CODE_FULL = 12'hfff;
    // host sclk divider: half period in hclk cycles (link period 160 ns)
    localparam int LINK_PERIOD_NS = 160;
    localparam int HCLK_PERIOD_NS = 10;
    localparam int HALF_CYCLES = LINK_PERIOD_NS / (2 * HCLK_PERIOD_NS);
    localparam logic [3:0] HALF_CNT = 4'(HALF_CYCLES - 1);
    // least frame-high gap between writes, in link half periods
    localparam logic [3:0] GAP_HALVES = 4'h4;
    // host register map (AHB-Lite word offsets)
    localparam logic [7:0] REG_TX = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ABORT = 8'h08;
    localparam logic [7:0] REG_ABORTCNT = 8'h0c;
    typedef enum logic [1:0] {
        DSW_MODE_NORMAL = 2'b00,
        DSW_MODE_PD_5K = 2'b01,
        DSW_MODE_PD_100K = 2'b10,
        DSW_MODE_PD_HIZ = 2'b11
    } dsw_mode_e;
endpackage : dsw_pkg
`default_nettype wire

// File: logic/dsw_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dsw_link_if;
    logic frame_n;
    logic sclk;
    logic sdata;
    modport host (output frame_n, output sclk, output sdata);
    modport dev (input frame_n, input sclk, input sdata);
endinterface : dsw_link_if
`default_nettype wire

// File: logic/dsw_device.sv
// What this block does
// - mode bits pick normal or three power-downs
// - host opens each write by lowering frame
// - shift data on falling sclk while framed
// - sixteenth falling edge loads code and mode
// - host raises frame for minimum gap
// - frame fall after high starts new write
// - two leading bits are ignored
// - early frame rise discards whole write
// - host sends most significant bit first
// - byte hosts keep frame low across bytes
// - host data valid at falling sclk
// - host idles frame and data low
// - code and output zero after reset
// - code is straight binary 0 to 4095
`timescale 1ns/1ps
`default_nettype none
module dsw_device (
    // system
    input wire logic hclk,
    input wire logic hresetn,
    // link
    dsw_link_if.dev link,
    // converter side
    output logic [11:0] code,
    output logic [1:0] mode,
    output logic pd_5k,
    output logic pd_100k,
    output logic out_hiz,
    output logic update
);
    ////////////////////////////////////////////////////////////////
    logic [1:0] fr_sync_ff, ck_sync_ff, dt_sync_ff;
    logic fr_q_ff, ck_q_ff;
    logic [15:0] sh_ff, nxt_sh;
    logic [4:0] cnt_ff, nxt_cnt;
    logic done_ff, nxt_done;
    logic [11:0] code_ff, nxt_code;
    logic [1:0] mode_ff, nxt_mode;
    logic pd5_ff, pd100_ff, hiz_ff, upd_ff;
    logic nxt_pd5, nxt_pd100, nxt_hiz, nxt_upd;
    logic fr_low, ck_fall, fr_fall;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fr_sync_ff <= 2'h3;
            ck_sync_ff <= 2'h0;
            dt_sync_ff <= 2'h0;
            fr_q_ff <= 1'b1;
            ck_q_ff <= 1'b0;
        end else begin
            fr_sync_ff <= {fr_sync_ff[0], link.frame_n};
            ck_sync_ff <= {ck_sync_ff[0], link.sclk};
            dt_sync_ff <= {dt_sync_ff[0], link.sdata};
            fr_q_ff <= fr_sync_ff[1];
            ck_q_ff <= ck_sync_ff[1];
        end
    end

    assign fr_low = !fr_sync_ff[1];
    assign ck_fall = ck_q_ff && !ck_sync_ff[1];
    assign fr_fall = fr_q_ff && fr_low;

    ////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_sh = sh_ff;
        nxt_cnt = cnt_ff;
        nxt_done = done_ff;
        nxt_code = code_ff;
        nxt_mode = mode_ff;
        nxt_upd = 1'b0;
        if (!fr_low) begin
            // frame high: any partial word is dropped
            nxt_sh = 16'h0000;
            nxt_cnt = 5'h00;
            nxt_done = 1'b0;
        end else begin
            if (fr_fall) begin
                nxt_cnt = 5'h00;
                nxt_done = 1'b0;
            end
            // edges after the sixteenth are ignored until frame rises
            if (ck_fall && !nxt_done) begin
                nxt_sh = {nxt_sh[14:0], dt_sync_ff[1]};
                nxt_cnt = nxt_cnt + 5'h01;
                if (nxt_cnt == dsw_pkg::LAST_EDGE) begin
                    nxt_done = 1'b1;
                    // bits 15:14 dropped on purpose
                    nxt_mode = {nxt_sh[dsw_pkg::MODE_HI_POS], nxt_sh[dsw_pkg::MODE_LO_POS]};
                    nxt_code = nxt_sh[dsw_pkg::CODE_BITS-1:0];
                    nxt_upd = 1'b1;
                end
            end
        end
    end

    always_comb begin
        nxt_pd5 = (nxt_mode == dsw_pkg::DSW_MODE_PD_5K);
        nxt_pd100 = (nxt_mode == dsw_pkg::DSW_MODE_PD_100K);
        nxt_hiz = (nxt_mode == dsw_pkg::DSW_MODE_PD_HIZ);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sh_ff <= 16'h0000;
            cnt_ff <= 5'h00;
            done_ff <= 1'b0;
            code_ff <= dsw_pkg::CODE_RESET;
            mode_ff <= dsw_pkg::DSW_MODE_NORMAL;
            pd5_ff <= 1'b0;
            pd100_ff <= 1'b0;
            hiz_ff <= 1'b0;
            upd_ff <= 1'b0;
        end else begin
            sh_ff <= nxt_sh;
            cnt_ff <= nxt_cnt;
            done_ff <= nxt_done;
            code_ff <= nxt_code;
            mode_ff <= nxt_mode;
            pd5_ff <= nxt_pd5;
            pd100_ff <= nxt_pd100;
            hiz_ff <= nxt_hiz;
            upd_ff <= nxt_upd;
        end
    end

    assign code = code_ff;
    assign mode = mode_ff;
    assign pd_5k = pd5_ff;
    assign pd_100k = pd100_ff;
    assign out_hiz = hiz_ff;
    assign update = upd_ff;
endmodule : dsw_device
`default_nettype wire

// File: logic/dsw_host.sv
`timescale 1ns/1ps
`default_nettype none
module dsw_host (
    // system
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // link
    dsw_link_if.host link
);
    typedef enum logic [1:0] {
        DSW_ST_IDLE = 2'b00,
        DSW_ST_SHIFT = 2'b01,
        DSW_ST_GAP = 2'b10
    } dsw_hst_e;

    ////////////////////////////////////////////////////////////////
    logic ap_ff, aw_ff;
    logic [7:0] aa_ff;
    logic [31:0] rd_ff, nxt_rd;
    dsw_hst_e st_ff, nxt_st;
    logic [15:0] sh_ff, nxt_sh;
    logic [3:0] div_ff, nxt_div;
    logic [4:0] bits_ff, nxt_bits;
    logic [3:0] gap_ff, nxt_gap;
    logic fr_ff, nxt_fr, ck_ff, nxt_ck, dt_ff, nxt_dt;
    logic abort_ff, nxt_abort;
    logic [7:0] acnt_ff, nxt_acnt;
    logic tick, wr_tx, wr_abort;

    assign tick = (div_ff == 4'h0);
    assign wr_tx = ap_ff && aw_ff && (aa_ff == dsw_pkg::REG_TX);
    assign wr_abort = ap_ff && aw_ff && (aa_ff == dsw_pkg::REG_ABORT);

    always_comb begin
        nxt_rd = 32'h0000_0000;
        if (hsel && hready && htrans[1] && !hwrite) begin
            if (haddr == dsw_pkg::REG_STATUS) begin
                nxt_rd = {30'h0, abort_ff, st_ff != DSW_ST_IDLE};
            end else if (haddr == dsw_pkg::REG_ABORTCNT) begin
                nxt_rd = {24'h0, acnt_ff};
            end else if (haddr == dsw_pkg::REG_TX) begin
                nxt_rd = {16'h0, sh_ff};
            end else begin
                nxt_rd = 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st = st_ff;
        nxt_sh = sh_ff;
        nxt_bits = bits_ff;
        nxt_gap = gap_ff;
        nxt_fr = fr_ff;
        nxt_ck = ck_ff;
        nxt_dt = dt_ff;
        nxt_abort = abort_ff;
        nxt_acnt = acnt_ff;
        nxt_div = tick ? dsw_pkg::HALF_CNT : div_ff - 4'h1;
        if (wr_abort) begin
            nxt_abort = hwdata[0];
        end
        case (st_ff)
            DSW_ST_IDLE: begin
                if (wr_tx) begin
                    nxt_sh = hwdata[15:0];
                    nxt_fr = 1'b0;
                    nxt_dt = hwdata[15];
                    nxt_ck = 1'b1;
                    nxt_bits = 5'h00;
                    nxt_div = dsw_pkg::HALF_CNT;
                    nxt_st = DSW_ST_SHIFT;
                end
            end
            DSW_ST_SHIFT: begin
                if (tick) begin
                    nxt_ck = !ck_ff;
                    if (ck_ff) begin
                        nxt_bits = bits_ff + 5'h01;
                    end else begin
                        // data changes on rising edge, stable at falling
                        nxt_sh = {sh_ff[14:0], 1'b0};
                        nxt_dt = sh_ff[14];
                    end
                    // abort test: raise frame after eight bits
                    if (!ck_ff && (bits_ff == (abort_ff ? 5'h08 : dsw_pkg::LAST_EDGE))) begin
                        nxt_fr = 1'b1;
                        nxt_ck = 1'b0;
                        nxt_dt = 1'b0;
                        nxt_gap = dsw_pkg::GAP_HALVES;
                        nxt_st = DSW_ST_GAP;
                        if (abort_ff) begin
                            nxt_acnt = acnt_ff + 8'h01;
                        end
                    end
                end
            end
            DSW_ST_GAP: begin
                if (tick) begin
                    nxt_gap = gap_ff - 4'h1;
                    if (gap_ff == 4'h1) begin
                        nxt_fr = 1'b0;
                        nxt_st = DSW_ST_IDLE;
                    end
                end
            end
            default: nxt_st = DSW_ST_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_ff <= 1'b0;
            aw_ff <= 1'b0;
            aa_ff <= 8'h00;
            rd_ff <= 32'h0000_0000;
            st_ff <= DSW_ST_IDLE;
            sh_ff <= 16'h0000;
            div_ff <= 4'h0;
            bits_ff <= 5'h00;
            gap_ff <= 4'h0;
            fr_ff <= 1'b0;
            ck_ff <= 1'b0;
            dt_ff <= 1'b0;
            abort_ff <= 1'b0;
            acnt_ff <= 8'h00;
        end else begin
            ap_ff <= hsel && hready && htrans[1];
            aw_ff <= hwrite;
            aa_ff <= haddr;
            rd_ff <= nxt_rd;
            st_ff <= nxt_st;
            sh_ff <= nxt_sh;
            div_ff <= nxt_div;
            bits_ff <= nxt_bits;
            gap_ff <= nxt_gap;
            fr_ff <= nxt_fr;
            ck_ff <= nxt_ck;
            dt_ff <= nxt_dt;
            abort_ff <= nxt_abort;
            acnt_ff <= nxt_acnt;
        end
    end

    assign hrdata = rd_ff;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign link.frame_n = fr_ff;
    assign link.sclk = ck_ff;
    assign link.sdata = dt_ff;
endmodule : dsw_host
`default_nettype wire

// File: verif/dsw_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dsw_assertions (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // link
    input wire logic frame_n,
    input wire logic sclk,
    input wire logic sdata,
    // converter side
    input wire logic [11:0] code,
    input wire logic [1:0] mode,
    input wire logic pd_5k,
    input wire logic pd_100k,
    input wire logic out_hiz,
    input wire logic update
);
    logic sclk_ff, nxt_sclk, fr_ff, nxt_fr, done_ff, nxt_done, hit;
    logic [4:0] cnt_ff, nxt_cnt;
    logic [15:0] word_ff, nxt_word;
    ////////////////////////////////////////////////////////////////
    // reference count of falling edges at the pins
    always_comb begin
        // previous frame level: a last edge may land with the frame rise
        hit = sclk_ff && !sclk && !fr_ff && cnt_ff == 5'h0f;
        nxt_sclk = sclk;
        nxt_fr = frame_n;
        nxt_cnt = frame_n ? 5'h00 : cnt_ff;
        nxt_word = word_ff;
        nxt_done = (fr_ff && !frame_n) ? 1'b0 : (done_ff || hit);
        if (sclk_ff && !sclk && !fr_ff && cnt_ff < 5'h10) begin
            nxt_cnt = cnt_ff + 5'h01;
            nxt_word = {word_ff[14:0], sdata};
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_ff <= 1'b0;
            fr_ff <= 1'b0;
            done_ff <= 1'b0;
            cnt_ff <= 5'h00;
            word_ff <= 16'h0000;
        end else begin
            sclk_ff <= nxt_sclk;
            fr_ff <= nxt_fr;
            done_ff <= nxt_done;
            cnt_ff <= nxt_cnt;
            word_ff <= nxt_word;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    mode_decode_a: assert property (update |=> pd_5k == (mode == 2'b01) && pd_100k == (mode == 2'b10)
        && out_hiz == (mode == 2'b11)) else $error("mode flags wrong");
    load_exact_a: assert property (update |=> code == word_ff[11:0] && mode == word_ff[13:12])
        else $error("loaded word wrong");
    edge_update_a: assert property (hit |-> ##[1:6] update) else $error("no load after last edge");
    no_partial_a: assert property (update |-> done_ff) else $error("load without full word");
    hold_value_a: assert property (($changed(code) || $changed(mode)) |-> update || $past(update))
        else $error("output moved without load");
    one_pulse_a: assert property (update |=> !update) else $error("load pulse too long");
    reset_zero_a: assert property ($rose(hresetn) |-> code == 12'h000 && mode == 2'b00)
        else $error("output not zero after reset");
    data_valid_a: assert property (!frame_n && $fell(sclk) |-> $stable(sdata))
        else $error("data moved at falling edge");
    frame_gap_a: assert property ($rose(frame_n) |-> frame_n [*8]) else $error("frame gap too short");
    clock_idle_a: assert property (frame_n && $past(frame_n) |-> !sclk) else $error("clock runs outside frame");
    cover property (hit);
    cover property (update && mode == 2'b11);
    cover property ($rose(frame_n) && cnt_ff == 5'h08);
endmodule : dsw_assertions
`default_nettype wire

// File: verif/dac_serial_write_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dac_serial_write_port_tb_top;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pd_5k, pd_100k, out_hiz, update;
    logic [7:0] haddr;
    logic [1:0] htrans, mode;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [11:0] code;
    logic [11:0] cv [4] = '{12'hfff, 12'h000, 12'ha5c, 12'h5a3};
    int err_total, checks_done;
    dsw_link_if link ();
    dsw_host u_dsw_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .link(link.host));
    dsw_device u_dsw_device (.hclk(hclk), .hresetn(hresetn), .link(link.dev), .code(code), .mode(mode),
        .pd_5k(pd_5k), .pd_100k(pd_100k), .out_hiz(out_hiz), .update(update));
    dsw_assertions u_dsw_assertions (.hclk(hclk), .hresetn(hresetn), .frame_n(link.frame_n), .sclk(link.sclk),
        .sdata(link.sdata), .code(code), .mode(mode), .pd_5k(pd_5k), .pd_100k(pd_100k), .out_hiz(out_hiz),
        .update(update));
    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    // polls instead of counting cycles: frame length is the host's business
    task automatic send(input logic [15:0] w);
        bus(dsw_pkg::REG_TX, 1'b1, {16'h0000, w});
        for (int i = 0; i < 400; i++) begin
            bus(dsw_pkg::REG_STATUS, 1'b0, 32'h0);
            if (rd[0] === 1'b0) break;
        end
        check("busy", {31'h0, rd[0]}, 32'h0);
    endtask : send
    task automatic expect_out(input logic [11:0] c, input logic [1:0] m);
        check("code", {20'h0, code}, {20'h0, c});
        check("mode", {30'h0, mode}, {30'h0, m});
        check("flags", {29'h0, pd_5k, pd_100k, out_hiz}, {29'h0, m == 2'b01, m == 2'b10, m == 2'b11});
    endtask : expect_out
    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        #100000;
        err_total++;
        complete_run();
    end
    initial begin
        err_total = 0;
        checks_done = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        expect_out(12'h000, 2'b00);
        // leading bits vary so a decoder that reads them shows up
        for (int m = 0; m < 4; m++) begin
            send({2'(3 - m), 2'(m), cv[m]});
            expect_out(cv[m], 2'(m));
        end
        check("idle", {29'h0, link.frame_n, link.sclk, link.sdata}, 32'h0);
        bus(dsw_pkg::REG_ABORT, 1'b1, 32'h1);
        bus(dsw_pkg::REG_STATUS, 1'b0, 32'h0);
        check("abort mode", rd, 32'h2);
        send(16'h0123);
        expect_out(12'h5a3, 2'b11);
        bus(dsw_pkg::REG_ABORTCNT, 1'b0, 32'h0);
        check("aborts", rd, 32'h1);
        bus(dsw_pkg::REG_ABORT, 1'b1, 32'h0);
        send(16'h1abc);
        expect_out(12'habc, 2'b01);
        // second start lands while busy and must be dropped
        bus(dsw_pkg::REG_TX, 1'b1, 32'h2456);
        send(16'h0777);
        expect_out(12'h456, 2'b10);
        bus(8'h10, 1'b0, 32'h0);
        check("unmapped", rd, 32'h0);
        complete_run();
    end
endmodule : dac_serial_write_port_tb_top
`default_nettype wire
